// ---- fegs_array_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// array macro stand-in
// ----------------------------------------
module fegs_array_model
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic arr_start_i,
    input wire logic arr_rd_en_i,
    input wire logic [17:0] arr_rd_addr_i,
    input wire logic [7:0] lat_i,
    output logic arr_done_o,
    output logic [31:0] arr_rd_data_o
);
    logic [7:0] cnt_q;

    // one done pulse per start, lat_i cycles later
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            cnt_q <= 8'h00;
        else if (arr_start_i)
            cnt_q <= (lat_i == 8'h00) ? 8'h01 : lat_i;
        else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
    end
    assign arr_done_o = (cnt_q == 8'h01);

    // data toggles outside reads so stale data never matches
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            arr_rd_data_o <= 32'h0000_0000;
        else if (arr_rd_en_i)
            arr_rd_data_o <= {~arr_rd_addr_i[13:0], arr_rd_addr_i};
        else
            arr_rd_data_o <= ~arr_rd_data_o;
    end
endmodule : fegs_array_model

// ---- fegs_geometry.sv ----
`timescale 1ns/1ps
`include "fegs_regs.svh"

// page number to the erase region that holds it
module fegs_geometry
    import fegs_pkg::*;
(
    input wire logic [10:0] page_i,
    output logic [10:0] region_first_o,
    output logic [11:0] region_pages_o,
    output logic small_o,
    output logic low_sector_o
);

    // ----------------------------------------------------------------
    // region decode
    // ----------------------------------------------------------------
    // lowest sector splits 16 / 16 / 96 pages, the rest are 128
    always_comb
    begin
        low_sector_o = (page_i[10:`FEGS_SECTOR_SHIFT] == 4'h0);
        small_o = 1'b0;
        region_first_o = {page_i[10:`FEGS_SECTOR_SHIFT], 7'h00};
        region_pages_o = `FEGS_SECTOR_PAGES;
        if (low_sector_o)
        begin
            if (page_i < `FEGS_LARGE_FIRST)
            begin
                small_o = 1'b1;
                region_first_o = {page_i[10:`FEGS_LOCK_SHIFT], 4'h0};
                region_pages_o = `FEGS_SMALL_PAGES;
            end
            else
            begin
                region_first_o = `FEGS_LARGE_FIRST;
                region_pages_o = `FEGS_LARGE_PAGES;
            end
        end
    end

endmodule : fegs_geometry

// ---- fegs_pkg.sv ----
package fegs_pkg;

    // software commands
    typedef enum logic [3:0] {
        FEGS_CMD_GET_DESC,
        FEGS_CMD_WRITE_PAGE,
        FEGS_CMD_WRITE_PAGE_LOCK,
        FEGS_CMD_ERASE_WRITE_PAGE,
        FEGS_CMD_ERASE_WRITE_PAGE_LOCK,
        FEGS_CMD_ERASE_ALL,
        FEGS_CMD_ERASE_PAGES,
        FEGS_CMD_ERASE_SECTOR,
        FEGS_CMD_SET_LOCK,
        FEGS_CMD_CLEAR_LOCK
    } fegs_cmd_e;

    // operations handed to the array macro
    typedef enum logic [1:0] {
        FEGS_ARR_ERASE,
        FEGS_ARR_PROGRAM,
        FEGS_ARR_ERASE_PROGRAM
    } fegs_arr_op_e;

    typedef struct packed {
        fegs_cmd_e op;
        logic [15:0] arg;
    } fegs_cmd_s;

    typedef struct packed {
        fegs_arr_op_e op;
        logic [10:0] first_page;
        logic [11:0] page_count;
    } fegs_arr_req_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [19:0] addr;
        logic [31:0] wdata;
    } fegs_bus_req_s;

    typedef struct packed {
        logic busy;
        logic done;
        logic cmd_err;
        logic lock_err;
    } fegs_status_s;

endpackage : fegs_pkg

// ---- fegs_regs.svh ----
`ifndef FEGS_REGS_SVH
`define FEGS_REGS_SVH

// ----------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------
`define FEGS_PAGE_BYTES 512
`define FEGS_PAGE_W 11
`define FEGS_TOTAL_PAGES 12'h800
`define FEGS_TOTAL_KBYTES 1024
`define FEGS_SECTOR_KBYTES 64
`define FEGS_SECTOR_PAGES 12'h080
`define FEGS_SECTOR_SHIFT 7
`define FEGS_SMALL_KBYTES 8
`define FEGS_SMALL_PAGES 12'h010
`define FEGS_LARGE_KBYTES 48
`define FEGS_LARGE_PAGES 12'h060
`define FEGS_LARGE_FIRST 11'h020
`define FEGS_LOCK_REGIONS 128
`define FEGS_LOCK_SHIFT 4
`define FEGS_WBUF_WORDS 128

// ----------------------------------------------------------------
// command argument fields
// ----------------------------------------------------------------
`define FEGS_ARG_EPA_CODE_LSB 0
`define FEGS_ARG_EPA_PAGE_LSB 2
`define FEGS_ARG_PAGE_LSB 0
`define FEGS_EPA_CODE_4 2'h0
`define FEGS_EPA_CODE_8 2'h1
`define FEGS_EPA_CODE_16 2'h2
`define FEGS_EPA_CODE_32 2'h3

// ----------------------------------------------------------------
// timing and descriptor
// ----------------------------------------------------------------
`define FEGS_MIN_WRITE_CLK_KHZ 330
`define FEGS_DESC_WORDS 3'h6

`endif

// ---- fegs_seq_monitor.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// sequencer port checker
// ----------------------------------------
module fegs_seq_monitor
    import fegs_pkg::*;
#(
    parameter int LOCK_REGIONS = 128
)
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic cmd_valid_i,
    input wire fegs_cmd_s cmd_i,
    input wire logic cmd_ready_o,
    input wire fegs_status_s status_o,
    input wire logic desc_valid_o,
    input wire logic [LOCK_REGIONS-1:0] lock_bits_o,
    input wire fegs_bus_req_s bus_i,
    input wire logic bus_ready_o,
    input wire logic bus_rvalid_o,
    input wire logic [31:0] bus_rdata_o,
    input wire logic bus_wack_o,
    input wire logic arr_rd_en_o,
    input wire logic [17:0] arr_rd_addr_o,
    input wire logic [31:0] arr_rd_data_i,
    input wire logic arr_start_o,
    input wire fegs_arr_req_s arr_req_o,
    input wire logic arr_done_i
);
    logic acc;
    logic free;
    logic [11:0] epa_cnt;
    logic [10:0] epa_first;
    logic [11:0] es_cnt;
    logic [10:0] es_first;

    // expected regions hold only while nothing is locked
    assign acc = cmd_valid_i && cmd_ready_o;
    assign free = (lock_bits_o == '0);
    assign epa_cnt = 12'h004 << cmd_i.arg[1:0];
    assign epa_first = cmd_i.arg[12:2] & ~(epa_cnt[10:0] - 11'h001);
    assign es_cnt = (cmd_i.arg[10:5] == 6'h00) ? 12'h010 : (cmd_i.arg[10:7] == 4'h0) ? 12'h060 : 12'h080;
    assign es_first = (es_cnt == 12'h010) ? {cmd_i.arg[10:4], 4'h0} :
                      (es_cnt == 12'h060) ? 11'h020 : {cmd_i.arg[10:7], 7'h00};

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);

    AST_ES_REGION: assert property (acc && cmd_i.op == FEGS_CMD_ERASE_SECTOR && free |=> arr_start_o
        && arr_req_o.first_page == $past(es_first) && arr_req_o.page_count == $past(es_cnt)) else $error("sector region");
    AST_EPA_BLOCK: assert property (acc && cmd_i.op == FEGS_CMD_ERASE_PAGES && free
        && ((cmd_i.arg[12:7] == 6'h00) ? !cmd_i.arg[1] : cmd_i.arg[1:0] != 2'h0) |=> arr_start_o
        && arr_req_o.first_page == $past(epa_first) && arr_req_o.page_count == $past(epa_cnt)) else $error("page block");
    AST_EPA_SMALL_REFUSE: assert property (acc && cmd_i.op == FEGS_CMD_ERASE_PAGES && free && cmd_i.arg[12:7] == 6'h00
        && cmd_i.arg[1] |=> status_o.cmd_err && !arr_start_o) else $error("small code refused");
    AST_EWP_REFUSE: assert property (acc && free && cmd_i.arg[10:5] != 6'h00 && (cmd_i.op == FEGS_CMD_ERASE_WRITE_PAGE
        || cmd_i.op == FEGS_CMD_ERASE_WRITE_PAGE_LOCK) |=> status_o.cmd_err && !arr_start_o) else $error("ewp outside");
    AST_LOCK_ABORT: assert property (acc && cmd_i.op == FEGS_CMD_ERASE_SECTOR && lock_bits_o[cmd_i.arg[10:4]]
        |=> status_o.lock_err && !arr_start_o) else $error("locked erase ran");
    AST_DONE_END: assert property (status_o.busy && arr_done_i |=> status_o.done && !status_o.busy && cmd_ready_o)
        else $error("done or busy wrong");
    AST_DESC_RUN: assert property (acc && cmd_i.op == FEGS_CMD_GET_DESC |-> ##2 desc_valid_o [*6] ##0 status_o.done)
        else $error("descriptor run");
    AST_READ_PATH: assert property (bus_i.valid && !bus_i.write && bus_ready_o |-> arr_rd_en_o
        && arr_rd_addr_o == bus_i.addr[19:2] ##2 bus_rvalid_o && bus_rdata_o == $past(arr_rd_data_i)) else $error("read");
    AST_WRITE_ACK: assert property (bus_i.valid && bus_i.write && bus_ready_o |=> bus_wack_o)
        else $error("write ack");

    // main scenarios reached
    cover property (acc && cmd_i.op == FEGS_CMD_ERASE_ALL);
    cover property (status_o.lock_err);
    cover property (desc_valid_o ##1 status_o.done);
endmodule : fegs_seq_monitor

bind fegs_sequencer fegs_seq_monitor #(.LOCK_REGIONS(LOCK_REGIONS)) i_seq_mon (
    .core_clk_i, .srst_i, .cmd_valid_i, .cmd_i, .cmd_ready_o, .status_o, .desc_valid_o, .lock_bits_o, .bus_i,
    .bus_ready_o, .bus_rvalid_o, .bus_rdata_o, .bus_wack_o, .arr_rd_en_o, .arr_rd_addr_o, .arr_rd_data_i,
    .arr_start_o, .arr_req_o, .arr_done_i
);

// ---- fegs_sequencer.sv ----
`timescale 1ns/1ps
`include "fegs_regs.svh"

// Functional notes
// - array addressed in 512-byte pages; all sectors are whole pages.
// - array divided into 64-Kbyte sectors, the sector erase units.
// - lowest sector splits into 8K, 8K, then 48K sub-sectors.
// - small sub-sectors hold 16 pages each, the large one 96 pages.
// - every higher sector is 128 pages, one uniform erase unit.
// - capacity 1024 Kbytes: 2x8K, 1x48K, fifteen 64K sectors.
// - small sub-sectors accept erase-write-page and its locking variant.
// - sector erase takes any page and erases its whole (sub-)sector.
// - erase-pages in small sub-sector: code 0 four pages, 1 eight.
// - erase-pages in 48K/64K sectors: codes 1,2,3 give 8,16,32 pages.
// - erase-all erases the whole plane in one operation.
// - bus reads return array data; bus writes fill the write buffer.
// - command and status interface is the controller's register slave port.
// - program, erase, lock, unlock run autonomously after a command.
// - a command returns a descriptor of the flash organisation.
// - erase or program on a locked region aborts and raises an event.
module fegs_sequencer
    import fegs_pkg::*;
#(
    parameter logic [31:0] DESC_ID = 32'h0000_1234, // arbitrary value
    parameter int WBUF_WORDS = `FEGS_WBUF_WORDS,
    parameter int LOCK_REGIONS = `FEGS_LOCK_REGIONS
)
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    // command port
    input wire logic cmd_valid_i,
    input wire fegs_cmd_s cmd_i,
    output logic cmd_ready_o,
    output fegs_status_s status_o,
    output logic desc_valid_o,
    output logic [31:0] desc_data_o,
    output logic [LOCK_REGIONS-1:0] lock_bits_o,
    // system bus side
    input wire fegs_bus_req_s bus_i,
    output logic bus_ready_o,
    output logic bus_rvalid_o,
    output logic [31:0] bus_rdata_o,
    output logic bus_wack_o,
    // array macro
    output logic arr_rd_en_o,
    output logic [17:0] arr_rd_addr_o,
    input wire logic [31:0] arr_rd_data_i,
    output logic arr_start_o,
    output fegs_arr_req_s arr_req_o,
    input wire logic arr_done_i,
    input wire logic [6:0] arr_buf_idx_i,
    output logic [31:0] arr_buf_data_o
);

    typedef enum logic [1:0] {
        FEGS_ST_IDLE,
        FEGS_ST_ARRAY,
        FEGS_ST_DESC
    } fegs_state_e;

    fegs_state_e state_q;
    fegs_state_e state_d;
    logic [31:0] wbuf_q [WBUF_WORDS];
    logic [LOCK_REGIONS-1:0] lock_q;
    logic lock_after_q;
    logic [10:0] op_page_q;
    logic [2:0] desc_idx_q;
    logic rd_pend_q;

    logic accept;
    logic [10:0] page;
    logic [10:0] epa_page;
    logic [10:0] reg_first;
    logic [11:0] reg_pages;
    logic in_small;
    logic in_low;
    logic legal;
    logic is_array_op;
    fegs_arr_req_s req_d;
    logic range_locked;
    logic [11:0] last_page;

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    assign accept = cmd_valid_i && cmd_ready_o;
    assign cmd_ready_o = (state_q == FEGS_ST_IDLE);
    assign page = cmd_i.arg[`FEGS_ARG_PAGE_LSB +: `FEGS_PAGE_W];
    assign epa_page = cmd_i.arg[`FEGS_ARG_EPA_PAGE_LSB +: `FEGS_PAGE_W];

    fegs_geometry u_geometry (
        .page_i((cmd_i.op == FEGS_CMD_ERASE_PAGES) ? epa_page : page),
        .region_first_o(reg_first),
        .region_pages_o(reg_pages),
        .small_o(in_small),
        .low_sector_o(in_low)
    );

    // legality, range and operation of the incoming command
    always_comb
    begin
        legal = 1'b1;
        is_array_op = 1'b1;
        req_d.op = FEGS_ARR_ERASE;
        req_d.first_page = page;
        req_d.page_count = 12'h001;
        case (cmd_i.op)
            FEGS_CMD_WRITE_PAGE, FEGS_CMD_WRITE_PAGE_LOCK:
            begin
                req_d.op = FEGS_ARR_PROGRAM;
            end
            FEGS_CMD_ERASE_WRITE_PAGE, FEGS_CMD_ERASE_WRITE_PAGE_LOCK:
            begin
                req_d.op = FEGS_ARR_ERASE_PROGRAM;
                legal = in_small;
            end
            FEGS_CMD_ERASE_SECTOR:
            begin
                req_d.first_page = reg_first;
                req_d.page_count = reg_pages;
            end
            FEGS_CMD_ERASE_ALL:
            begin
                req_d.first_page = 11'h000;
                req_d.page_count = `FEGS_TOTAL_PAGES;
            end
            FEGS_CMD_ERASE_PAGES:
            begin
                case (cmd_i.arg[`FEGS_ARG_EPA_CODE_LSB +: 2])
                    `FEGS_EPA_CODE_4:
                    begin
                        legal = in_small;
                        req_d.first_page = {epa_page[10:2], 2'h0};
                        req_d.page_count = 12'h004;
                    end
                    `FEGS_EPA_CODE_8:
                    begin
                        req_d.first_page = {epa_page[10:3], 3'h0};
                        req_d.page_count = 12'h008;
                    end
                    `FEGS_EPA_CODE_16:
                    begin
                        legal = !in_small;
                        req_d.first_page = {epa_page[10:4], 4'h0};
                        req_d.page_count = 12'h010;
                    end
                    default:
                    begin
                        legal = !in_small;
                        req_d.first_page = {epa_page[10:5], 5'h00};
                        req_d.page_count = 12'h020;
                    end
                endcase
            end
            default:
            begin
                is_array_op = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // lock check
    // ----------------------------------------------------------------
    // any lock bit inside the target range blocks the whole command
    assign last_page = {1'b0, req_d.first_page} + req_d.page_count - 12'h001;

    always_comb
    begin
        range_locked = 1'b0;
        for (int i = 0; i < LOCK_REGIONS; i++)
        begin
            if (lock_q[i] && (i >= int'(req_d.first_page >> `FEGS_LOCK_SHIFT))
                && (i <= int'(last_page >> `FEGS_LOCK_SHIFT)))
            begin
                range_locked = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            FEGS_ST_IDLE:
            begin
                if (accept && cmd_i.op == FEGS_CMD_GET_DESC)
                begin
                    state_d = FEGS_ST_DESC;
                end
                else if (accept && is_array_op && legal && !range_locked)
                begin
                    state_d = FEGS_ST_ARRAY;
                end
            end
            FEGS_ST_ARRAY:
            begin
                if (arr_done_i)
                begin
                    state_d = FEGS_ST_IDLE;
                end
            end
            FEGS_ST_DESC:
            begin
                if (desc_idx_q == `FEGS_DESC_WORDS - 3'h1)
                begin
                    state_d = FEGS_ST_IDLE;
                end
            end
            default:
            begin
                state_d = FEGS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            state_q <= FEGS_ST_IDLE;
        else
            state_q <= state_d;
    end

    // array start pulse and the request held for the whole operation
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            arr_start_o <= 1'b0;
            arr_req_o <= '0;
            lock_after_q <= 1'b0;
            op_page_q <= 11'h000;
        end
        else
        begin
            arr_start_o <= (state_q == FEGS_ST_IDLE) && (state_d == FEGS_ST_ARRAY);
            if ((state_q == FEGS_ST_IDLE) && (state_d == FEGS_ST_ARRAY))
            begin
                arr_req_o <= req_d;
                op_page_q <= page;
                lock_after_q <= (cmd_i.op == FEGS_CMD_WRITE_PAGE_LOCK)
                    || (cmd_i.op == FEGS_CMD_ERASE_WRITE_PAGE_LOCK);
            end
        end
    end

    // ----------------------------------------------------------------
    // lock bits
    // ----------------------------------------------------------------
    // lock and unlock finish in the accept cycle; locking variants wait for the array
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            lock_q <= '0;
        else if (accept && cmd_i.op == FEGS_CMD_SET_LOCK)
            lock_q[page[10:`FEGS_LOCK_SHIFT]] <= 1'b1;
        else if (accept && cmd_i.op == FEGS_CMD_CLEAR_LOCK)
            lock_q[page[10:`FEGS_LOCK_SHIFT]] <= 1'b0;
        else if (state_q == FEGS_ST_ARRAY && arr_done_i && lock_after_q)
            lock_q[op_page_q[10:`FEGS_LOCK_SHIFT]] <= 1'b1;
    end

    assign lock_bits_o = lock_q;

    // ----------------------------------------------------------------
    // status
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            status_o <= '0;
        end
        else
        begin
            status_o.busy <= (state_d != FEGS_ST_IDLE);
            status_o.cmd_err <= accept && is_array_op && !legal;
            status_o.lock_err <= accept && is_array_op && legal && range_locked;
            status_o.done <= (state_q == FEGS_ST_ARRAY && arr_done_i)
                || (state_q == FEGS_ST_DESC && state_d == FEGS_ST_IDLE)
                || (accept && (cmd_i.op == FEGS_CMD_SET_LOCK || cmd_i.op == FEGS_CMD_CLEAR_LOCK));
        end
    end

    // ----------------------------------------------------------------
    // descriptor stream
    // ----------------------------------------------------------------
    // id, total bytes, page bytes, planes, plane bytes, lock region count
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            desc_idx_q <= 3'h0;
            desc_valid_o <= 1'b0;
            desc_data_o <= 32'h0000_0000;
        end
        else
        begin
            desc_valid_o <= (state_q == FEGS_ST_DESC);
            if (state_q == FEGS_ST_DESC)
                desc_idx_q <= desc_idx_q + 3'h1;
            else
                desc_idx_q <= 3'h0;
            case (desc_idx_q)
                3'h0: desc_data_o <= DESC_ID;
                3'h1: desc_data_o <= 32'(`FEGS_TOTAL_KBYTES * 1024);
                3'h2: desc_data_o <= 32'(`FEGS_PAGE_BYTES);
                3'h3: desc_data_o <= 32'h0000_0001;
                3'h4: desc_data_o <= 32'(`FEGS_TOTAL_KBYTES * 1024);
                default: desc_data_o <= 32'(LOCK_REGIONS);
            endcase
        end
    end

    // ----------------------------------------------------------------
    // system bus: array reads, write buffer fills
    // ----------------------------------------------------------------
    // reads stall during array operations since the macro is not readable then
    assign bus_ready_o = (state_q != FEGS_ST_ARRAY);
    assign arr_rd_en_o = bus_i.valid && !bus_i.write && bus_ready_o;
    assign arr_rd_addr_o = bus_i.addr[19:2];

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            rd_pend_q <= 1'b0;
            bus_rvalid_o <= 1'b0;
            bus_rdata_o <= 32'h0000_0000;
            bus_wack_o <= 1'b0;
        end
        else
        begin
            rd_pend_q <= arr_rd_en_o;
            bus_rvalid_o <= rd_pend_q;
            if (rd_pend_q)
                bus_rdata_o <= arr_rd_data_i;
            bus_wack_o <= bus_i.valid && bus_i.write && bus_ready_o;
        end
    end

    // write buffer holds one page; the array pulls it while programming
    always_ff @(posedge core_clk_i)
    begin
        if (bus_i.valid && bus_i.write && bus_ready_o)
            wbuf_q[bus_i.addr[8:2]] <= bus_i.wdata;
    end

    assign arr_buf_data_o = wbuf_q[arr_buf_idx_i];

endmodule : fegs_sequencer

// ---- flash_erase_geometry_sequencer_tb_top.sv ----
`timescale 1ns/1ps
module flash_erase_geometry_sequencer_tb_top
    import fegs_pkg::*;
();
    localparam logic [31:0] DID = 32'h0000_5A5A; // arbitrary value
    logic clk, rst = 1'b1, cvalid = 1'b0, slow = 1'b0;
    logic cready, dvalid, bready, rvalid, rden, start, adone;
    logic [31:0] ddata, rdata, ardata, bdata;
    logic [127:0] locks;
    logic [17:0] raddr;
    logic [7:0] lat = 8'h01;
    logic [6:0] bidx = 7'h00;
    fegs_cmd_s cmd = '0;
    fegs_bus_req_s bus = '0;
    fegs_status_s st;
    fegs_arr_req_s areq;
    logic [31:0] q_arr[$], q_st[$], q_rd[$], q_desc[$];
    int bad_count = 0, checks_done = 0;

    fegs_sequencer #(.DESC_ID(DID)) i_dut (
        .core_clk_i(clk), .srst_i(rst), .cmd_valid_i(cvalid), .cmd_i(cmd), .cmd_ready_o(cready),
        .status_o(st), .desc_valid_o(dvalid), .desc_data_o(ddata), .lock_bits_o(locks), .bus_i(bus),
        .bus_ready_o(bready), .bus_rvalid_o(rvalid), .bus_rdata_o(rdata), .bus_wack_o(),
        .arr_rd_en_o(rden), .arr_rd_addr_o(raddr), .arr_rd_data_i(ardata), .arr_start_o(start),
        .arr_req_o(areq), .arr_done_i(adone), .arr_buf_idx_i(bidx), .arr_buf_data_o(bdata)
    );
    fegs_array_model i_arr (
        .core_clk_i(clk), .srst_i(rst), .arr_start_i(start), .arr_rd_en_i(rden),
        .arr_rd_addr_i(raddr), .lat_i(lat), .arr_done_o(adone), .arr_rd_data_o(ardata)
    );

    // 100 MHz, far above the write-command minimum
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report;
        if (q_arr.size() + q_st.size() + q_rd.size() + q_desc.size() != 0)
            bad_count++;
        if (bad_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_arr(input fegs_arr_req_s got, input logic [31:0] exp);
        cmp_word({7'h00, got}, exp);
    endtask : cmp_arr

    function automatic logic [31:0] pop(ref logic [31:0] q[$]);
        return (q.size() != 0) ? q.pop_front() : 32'hFFFF_FFFF;
    endfunction : pop

    // each result pulse retires its oldest note
    always @(negedge clk)
    begin
        if (!rst && start)
            cmp_arr(areq, pop(q_arr));
        if (!rst && (st.done || st.cmd_err || st.lock_err))
            cmp_word({29'h0, st.done, st.cmd_err, st.lock_err}, pop(q_st));
        if (!rst && rvalid)
            cmp_word(rdata, pop(q_rd));
        if (!rst && dvalid)
            cmp_word(ddata, pop(q_desc));
    end

    // request held until the edge that sees ready
    task automatic send(input fegs_cmd_e op, input logic [15:0] arg);
        int n = 0;
        @(posedge clk);
        lat <= slow ? 8'hC8 : 8'($urandom_range(12, 1));
        cvalid <= 1'b1;
        cmd <= '{op, arg};
        do
            @(negedge clk);
        while (cready !== 1'b1 && n++ < 3000);
        @(posedge clk);
        cvalid <= 1'b0;
    endtask : send

    task automatic op_ok(input fegs_cmd_e op, input logic [15:0] arg, input fegs_arr_op_e ao, input logic [10:0] f,
                         input logic [11:0] c);
        q_arr.push_back({7'h00, ao, f, c});
        q_st.push_back(32'h4);
        send(op, arg);
    endtask : op_ok

    task automatic op_st(input fegs_cmd_e op, input logic [15:0] arg, input logic [31:0] s);
        q_st.push_back(s);
        send(op, arg);
    endtask : op_st

    task automatic settle;
        int n = 0;
        repeat (2) @(negedge clk);
        while (cready !== 1'b1 && n++ < 3000)
            @(negedge clk);
    endtask : settle

    task automatic bus_op(input logic wr, input logic [19:0] a, input logic [31:0] d);
        int n = 0;
        if (!wr)
            q_rd.push_back({~a[15:2], a[19:2]});
        @(posedge clk);
        bus <= '{1'b1, wr, a, d};
        do
            @(negedge clk);
        while (bready !== 1'b1 && n++ < 3000);
        @(posedge clk);
        bus.valid <= 1'b0;
    endtask : bus_op

    // main sequence
    initial
    begin
        logic [33:0] es_t [6];
        logic [10:0] pg;
        logic [1:0] code;
        logic [11:0] c;
        logic [31:0] v;
        es_t = '{{11'h005, 11'h000, 12'h010}, {11'h01F, 11'h010, 12'h010}, {11'h020, 11'h020, 12'h060},
                 {11'h07F, 11'h020, 12'h060}, {11'h080, 11'h080, 12'h080}, {11'h7FF, 11'h780, 12'h080}};
        void'($urandom(32'h3B95));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            {pg, v[22:0]} = es_t[i];
            op_ok(FEGS_CMD_ERASE_SECTOR, 16'(pg), FEGS_ARR_ERASE, v[22:12], v[11:0]);
        end
        // erase pages: random pages and every legal code
        for (int i = 0; i < 8; i++)
        begin
            pg = (i < 2) ? 11'($urandom_range(31)) : 11'($urandom_range(2047, 32));
            code = (i < 2) ? 2'(i) : 2'(1 + i % 3);
            c = 12'h004 << code;
            op_ok(FEGS_CMD_ERASE_PAGES, {3'h0, pg, code}, FEGS_ARR_ERASE, pg & ~(c[10:0] - 11'h001), c);
        end
        op_st(FEGS_CMD_ERASE_PAGES, {3'h0, 11'h01F, 2'h2}, 32'h2);
        op_st(FEGS_CMD_ERASE_PAGES, {3'h0, 11'h000, 2'h3}, 32'h2);
        op_st(FEGS_CMD_ERASE_PAGES, {3'h0, 11'h020, 2'h0}, 32'h2);
        op_st(FEGS_CMD_ERASE_WRITE_PAGE, 16'h0020, 32'h2);
        op_st(FEGS_CMD_ERASE_WRITE_PAGE_LOCK, 16'h0400, 32'h2);
        op_ok(FEGS_CMD_ERASE_WRITE_PAGE, 16'h0003, FEGS_ARR_ERASE_PROGRAM, 11'h003, 12'h001);
        op_ok(FEGS_CMD_ERASE_WRITE_PAGE_LOCK, 16'h0011, FEGS_ARR_ERASE_PROGRAM, 11'h011, 12'h001);
        settle;
        cmp_word(locks[31:0], 32'h2);
        op_st(FEGS_CMD_CLEAR_LOCK, 16'h0011, 32'h4);
        op_st(FEGS_CMD_SET_LOCK, 16'h0030, 32'h4);
        op_st(FEGS_CMD_WRITE_PAGE_LOCK, 16'h0030, 32'h1);
        op_st(FEGS_CMD_ERASE_SECTOR, 16'h0034, 32'h1);
        op_st(FEGS_CMD_ERASE_ALL, 16'h0000, 32'h1);
        settle;
        cmp_word(locks[31:0], 32'h8);
        op_st(FEGS_CMD_CLEAR_LOCK, 16'h0030, 32'h4);
        op_ok(FEGS_CMD_WRITE_PAGE, 16'h0455, FEGS_ARR_PROGRAM, 11'h455, 12'h001);
        // buffer fill seen from the array side
        for (int i = 0; i < 4; i++)
        begin
            v = $urandom;
            bus_op(1'b1, 20'(i * 4), v);
            bidx <= 7'(i);
            @(negedge clk);
            cmp_word(bdata, v);
        end
        for (int i = 0; i < 4; i++)
            bus_op(1'b0, 20'($urandom) & 20'hFFFFC, 32'h0);
        // slow erase-all; a read waits behind it
        slow = 1'b1;
        fork
            op_ok(FEGS_CMD_ERASE_ALL, 16'h0000, FEGS_ARR_ERASE, 11'h000, 12'h800);
            begin
                repeat (4) @(posedge clk);
                bus_op(1'b0, 20'h0ABC4, 32'h0);
            end
        join
        slow = 1'b0;
        q_desc = '{DID, 32'h0010_0000, 32'h0000_0200, 32'h0000_0001, 32'h0010_0000, 32'h0000_0080};
        op_st(FEGS_CMD_GET_DESC, 16'h0000, 32'h4);
        settle;
        repeat (4) @(posedge clk);
        final_report();
    end

    // hang guard, far past the run's length
    initial
    begin
        #500000;
        bad_count++;
        final_report();
    end
endmodule : flash_erase_geometry_sequencer_tb_top
